// file: bench/pmic_platform_control_signals_tb.sv
// self-checking bench of the platform control sequencer
`timescale 1ns/100ps
`default_nettype none
`include "pmpc_map.svh"

module pmic_platform_control_signals_tb
  import pmpc_pkg::*;
;
  logic          clk = 1'b0;
  logic          sys_rst = 1'b1;
  logic          a_rails_good, memory_rail_above90, core_softstart_done;
  logic          irq_pending, fault_shutdown_req, button_input_n, mem_ok, ss_ok;
  logic [2:0]    temp_alert;
  pmpc_host_in_s req, host_in;
  pmpc_rail_en_s rail_en;
  logic          resume_reset_n, memory_rail_good_oe_n, core_rails_good_od_oe_n;
  logic          core_rails_good, interrupt_line, processor_hot_oe_n;
  logic          shutdown_warning_n, button_to_host_n;
  int            n_errors = 0;
  int            samples_checked = 0;

  always #12.5 clk = ~clk;

  pmpc_ctl dut (.clk(clk), .sys_rst(sys_rst), .clk_en(1'b1), .host_in(host_in),
    .a_rails_good(a_rails_good), .memory_rail_above90(memory_rail_above90),
    .core_softstart_done(core_softstart_done), .irq_pending(irq_pending),
    .temp_alert(temp_alert), .fault_shutdown_req(fault_shutdown_req),
    .button_input_n(button_input_n), .rail_en(rail_en), .resume_reset_n(resume_reset_n),
    .memory_rail_good_oe_n(memory_rail_good_oe_n), .core_rails_good_od_oe_n(core_rails_good_od_oe_n),
    .core_rails_good(core_rails_good), .interrupt_line(interrupt_line),
    .processor_hot_oe_n(processor_hot_oe_n), .shutdown_warning_n(shutdown_warning_n),
    .button_to_host_n(button_to_host_n));

  pmpc_host_model host (.clk(clk), .req(req), .resume_reset_n(resume_reset_n),
    .processor_hot_oe_n(processor_hot_oe_n), .host_in(host_in));

  // regulators answer on the falling edge after their enable
  always @(negedge clk) begin
    a_rails_good <= rail_en.a_rails;
    memory_rail_above90 <= rail_en.memory_rail & mem_ok;
    core_softstart_done <= rail_en.core_rails & ss_ok;
  end

  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic chk(logic got, logic exp, string what);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s", $time, what);
    end
  endtask

  task automatic tally_and_finish;
    $display("checked %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic t_power_up;
    mem_ok <= 1'b0;
    ss_ok <= 1'b0;
    irq_pending <= 1'b1;
    req.sleep_state3_n <= 1'b1;
    req.deep_sleep_n <= 1'b1;
    button_input_n <= 1'b0;
    cyc(1);
    chk(rail_en.a_rails, 1'b1, "a rails on");
    chk(resume_reset_n, 1'b0, "resume held");
    chk(interrupt_line, 1'b0, "irq masked in reset");
    chk(button_to_host_n, 1'b1, "button held back in reset");
    cyc(2);
    chk(resume_reset_n, 1'b1, "resume released");
    chk(interrupt_line, 1'b1, "irq raised");
    chk(button_to_host_n, 1'b0, "button passed to host");
    button_input_n <= 1'b1;
    req.platform_reset_n <= 1'b1;
    irq_pending <= 1'b0;
    cyc(5);
    chk(rail_en.memory_rail, 1'b1, "memory rail on");
    chk(memory_rail_good_oe_n, 1'b0, "memory good low");
    chk(core_rails_good, 1'b0, "core good low");
    mem_ok <= 1'b1;
    cyc(3);
    chk(memory_rail_good_oe_n, 1'b1, "memory good");
    ss_ok <= 1'b1;
    cyc(3);
    chk(core_rails_good_od_oe_n, 1'b1, "od core good");
    chk(core_rails_good, 1'b1, "core good");
    $display("test power_up done");
  endtask

  task automatic t_shallow;
    req.shallow_sleep_n <= 1'b0;
    cyc(2);
    chk(rail_en.power_save, 1'b0, "power save early");
    cyc(3);
    chk(rail_en.power_save, 1'b1, "power save");
    chk(core_rails_good, 1'b1, "core good in idle");
    req.shallow_sleep_n <= 1'b1;
    cyc(6);
    $display("test shallow done");
  endtask

  task automatic t_sleep;
    req.deep_sleep_n <= 1'b0;
    cyc(4);
    req.deep_sleep_n <= 1'b1;
    cyc(4);
    req.sleep_state3_n <= 1'b0;
    cyc(6);
    chk(shutdown_warning_n, 1'b0, "warn in power-down");
    chk(rail_en.core_rails, 1'b0, "core off first");
    chk(core_rails_good, 1'b0, "core good off");
    chk(rail_en.memory_rail, 1'b1, "memory still on");
    cyc(50);
    chk(rail_en.memory_rail, 1'b0, "memory off");
    cyc(50);
    chk(shutdown_warning_n, 1'b1, "warn released");
    req.suspend_powerdown_ack <= 1'b1;
    cyc(8);
    chk(rail_en.a_rails, 1'b1, "ack without deep");
    req.suspend_powerdown_ack <= 1'b0;
    cyc(2);
    $display("test sleep done");
  endtask

  task automatic t_hot_wake;
    temp_alert <= 3'h2;
    cyc(4);
    chk(processor_hot_oe_n, 1'b0, "hot asserted");
    req.sleep_state3_n <= 1'b1;
    cyc(8);
    chk(rail_en.memory_rail, 1'b0, "no wake while hot");
    temp_alert <= 3'h0;
    cyc(4);
    chk(processor_hot_oe_n, 1'b1, "hot released");
    cyc(8);
    chk(rail_en.memory_rail, 1'b1, "wake");
    $display("test hot_wake done");
  endtask

  task automatic t_suspend;
    req.sleep_state3_n <= 1'b0;
    cyc(100);
    req.deep_sleep_n <= 1'b0;
    cyc(6);
    req.suspend_powerdown_ack <= 1'b1;
    cyc(6);
    chk(shutdown_warning_n, 1'b0, "warn in a-rail off");
    chk(rail_en.a_rails, 1'b0, "a rails off");
    cyc(50);
    chk(resume_reset_n, 1'b0, "resume low");
    chk(shutdown_warning_n, 1'b1, "warn released");
    req.suspend_powerdown_ack <= 1'b0;
    $display("test suspend done");
  endtask

  task automatic t_thermal;
    req.platform_reset_n <= 1'b0;
    cyc(4);
    req.thermal_trip_n <= 1'b0;
    cyc(6);
    chk(rail_en.a_rails, 1'b1, "trip ignored");
    req.thermal_trip_n <= 1'b1;
    cyc(4);
    req.platform_reset_n <= 1'b1;
    cyc(6);
    req.thermal_trip_n <= 1'b0;
    cyc(6);
    chk(rail_en.a_rails, 1'b0, "trip rails off");
    chk(resume_reset_n, 1'b0, "trip resume low");
    chk(shutdown_warning_n, 1'b1, "trip no warning");
    req.thermal_trip_n <= 1'b1;
    $display("test thermal done");
  endtask

  task automatic t_fault;
    fault_shutdown_req <= 1'b1;
    cyc(1);
    fault_shutdown_req <= 1'b0;
    cyc(3);
    chk(shutdown_warning_n, 1'b0, "fault warning");
    cyc(3590);
    chk(rail_en.a_rails, 1'b1, "rails hold in warning");
    cyc(20);
    chk(rail_en.a_rails, 1'b0, "fault off");
    chk(resume_reset_n, 1'b0, "fault resume low");
    $display("test fault done");
  endtask

  // whole run is about 4000 cycles
  initial begin
    #(25 * 10000);
    n_errors++;
    $display("mismatch at %0t: watchdog", $time);
    tally_and_finish;
  end

  initial begin
    req = `PMPC_HOST_IDLE;
    {irq_pending, fault_shutdown_req, mem_ok, ss_ok} = 4'h0;
    button_input_n = 1'b1;
    temp_alert = 3'h0;
    cyc(20);
    sys_rst <= 1'b0;
    cyc(2);
    t_power_up;
    t_shallow;
    t_sleep;
    t_hot_wake;
    t_suspend;
    t_power_up;
    t_thermal;
    t_power_up;
    t_fault;
    tally_and_finish;
  end
endmodule // pmic_platform_control_signals_tb
`default_nettype wire

// file: bench/pmpc_ctl_assertions.sv
// concurrent checks on the platform control outputs
`timescale 1ns/100ps
`default_nettype none
`include "pmpc_map.svh"

module pmpc_ctl_assertions
  import pmpc_pkg::*;
(
  // clock and reset
  input wire logic          clk,
  input wire logic          sys_rst,
  // monitored inputs
  input wire logic          a_rails_good,
  input wire logic          memory_rail_above90,
  input wire logic          core_softstart_done,
  input wire logic          irq_pending,
  input wire logic [2:0]    temp_alert,
  input wire logic          button_input_n,
  // monitored outputs
  input wire pmpc_rail_en_s rail_en,
  input wire logic          resume_reset_n,
  input wire logic          memory_rail_good_oe_n,
  input wire logic          core_rails_good_od_oe_n,
  input wire logic          core_rails_good,
  input wire logic          interrupt_line,
  input wire logic          processor_hot_oe_n,
  input wire logic          shutdown_warning_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  logic [11:0] warn_cnt;

  // saturates so a stuck warning cannot wrap back to a short count
  always_ff @(posedge clk) begin
    if (sys_rst || shutdown_warning_n)
      warn_cnt <= 12'h000;
    else if (warn_cnt != 12'hfff)
      warn_cnt <= warn_cnt + 12'h001;
  end

  sequence s_hard_off;
    $fell(rail_en.a_rails) && !resume_reset_n && !$past(shutdown_warning_n);
  endsequence

  AST_RESUME_UP: assert property ($rose(resume_reset_n) |-> $past(a_rails_good) && rail_en.a_rails)
    else $error("resume released without always-on rails");
  AST_RESUME_DOWN: assert property ($fell(resume_reset_n) |-> !rail_en.a_rails)
    else $error("resume dropped with always-on rails on");
  AST_MEM_GOOD: assert property ($rose(memory_rail_good_oe_n) |-> $past(memory_rail_above90) && rail_en.memory_rail)
    else $error("memory good released early");
  AST_MEM_OFF: assert property (!rail_en.memory_rail && !$past(rail_en.memory_rail) |-> !memory_rail_good_oe_n)
    else $error("memory good high with rail off");
  AST_CORE_OD: assert property ($rose(core_rails_good_od_oe_n) |-> $past(core_softstart_done))
    else $error("open-drain core good before soft-start");
  AST_CORE_GOOD: assert property ($rose(core_rails_good) |-> $past(core_softstart_done))
    else $error("core good before soft-start");
  AST_IRQ: assert property (interrupt_line == ($past(irq_pending) && $past(resume_reset_n)))
    else $error("interrupt line wrong");
  AST_HOT_ON: assert property (!processor_hot_oe_n |-> $past(temp_alert) != 3'h0 && $past(resume_reset_n))
    else $error("processor hot without alert");
  AST_HOT_OFF: assert property ($past(temp_alert) == 3'h0 |-> processor_hot_oe_n)
    else $error("processor hot stuck");
  AST_WARN_PWRDN: assert property ($fell(rail_en.memory_rail) && resume_reset_n |-> !shutdown_warning_n)
    else $error("power-down without warning");
  AST_WARN_LEAD: assert property (s_hard_off |-> warn_cnt >= `PMPC_WARN_CYC)
    else $error("warning too short before hard off");
  AST_BUTTON: assert property ($rose(rail_en.a_rails) |-> !$past(button_input_n) && !resume_reset_n)
    else $error("rails started without button");
endmodule // pmpc_ctl_assertions

bind pmpc_ctl pmpc_ctl_assertions u_chk (
  .clk(clk), .sys_rst(sys_rst), .a_rails_good(a_rails_good),
  .memory_rail_above90(memory_rail_above90), .core_softstart_done(core_softstart_done),
  .irq_pending(irq_pending), .temp_alert(temp_alert), .button_input_n(button_input_n),
  .rail_en(rail_en), .resume_reset_n(resume_reset_n), .memory_rail_good_oe_n(memory_rail_good_oe_n),
  .core_rails_good_od_oe_n(core_rails_good_od_oe_n), .core_rails_good(core_rails_good),
  .interrupt_line(interrupt_line), .processor_hot_oe_n(processor_hot_oe_n),
  .shutdown_warning_n(shutdown_warning_n)
);
`default_nettype wire

// file: bench/pmpc_host_model.sv
// host system-on-chip stand-in driving the sleep and reset lines
`timescale 1ns/100ps
`default_nettype none

module pmpc_host_model
  import pmpc_pkg::*;
(
  // clock
  input wire logic          clk,
  // requested levels and device feedback
  input wire pmpc_host_in_s req,
  input wire logic          resume_reset_n,
  input wire logic          processor_hot_oe_n,
  // towards the device
  output pmpc_host_in_s     host_in
);
  pmpc_host_in_s drive;

  initial host_in = 6'h3d;
  always @(negedge clk) begin
    // exit settings are assumed sent on the side links before req moves
    drive = req;
    drive.platform_reset_n = req.platform_reset_n & resume_reset_n;
    // no wake while the processor is hot
    if (!processor_hot_oe_n && !host_in.sleep_state3_n)
      drive.sleep_state3_n = 1'b0;
    host_in <= drive;
  end
endmodule // pmpc_host_model
`default_nettype wire

// file: pkg/pmpc_map.svh
// timing constants for the platform control signal block
`ifndef PMPC_MAP_SVH
`define PMPC_MAP_SVH

// core clock rate
`define PMPC_CLK_KHZ 40000
// whole megahertz keeps the cycle products inside 32 bits
`define PMPC_CLK_MHZ (`PMPC_CLK_KHZ / 1000)

// least warning time before a catastrophic hard shutdown, in ns
`define PMPC_WARN_NS 90000
// rounded up to whole cycles
`define PMPC_WARN_CYC ((`PMPC_WARN_NS * `PMPC_CLK_MHZ + 999) / 1000)

// longest allowed latency of the interrupt line, in ns
`define PMPC_IRQ_LAT_NS 1000000
// rounded down to whole cycles; the logic answers in one cycle
`define PMPC_IRQ_LAT_CYC ((`PMPC_IRQ_LAT_NS * `PMPC_CLK_MHZ) / 1000)

// spacing between two steps of a power-down task list, in ns
`define PMPC_STEP_NS 1000
`define PMPC_STEP_CYC ((`PMPC_STEP_NS * `PMPC_CLK_MHZ + 999) / 1000)

// timer load width
`define PMPC_TMR_W 12

// idle levels of the synchronised host inputs
`define PMPC_HOST_IDLE 6'h3d

`endif

// file: pkg/pmpc_pkg.sv
// types for the platform control signal block
package pmpc_pkg;

  typedef enum logic [3:0] {
    PMPC_OFF,
    PMPC_A_UP,
    PMPC_STBY,
    PMPC_MAIN_UP,
    PMPC_ON,
    PMPC_PWRDN,
    PMPC_A_DOWN,
    PMPC_WARN
  } pmpc_state_e;

  // host inputs, bit order fixed for the synchroniser idle value
  typedef struct packed {
    logic shallow_sleep_n;
    logic sleep_state3_n;
    logic deep_sleep_n;
    logic platform_reset_n;
    logic suspend_powerdown_ack;
    logic thermal_trip_n;
  } pmpc_host_in_s;

  // rail enables towards the regulators
  typedef struct packed {
    logic a_rails;
    logic memory_rail;
    logic core_rails;
    logic power_save;
  } pmpc_rail_en_s;

  typedef struct packed {
    logic [11:0] cnt;
    logic        busy;
    logic        done;
  } pmpc_tmr_s;

  typedef struct packed {
    pmpc_state_e   st;
    logic [1:0]    step;
    logic          deep;
    logic          trip_prev;
    logic          btn_prev;
    logic          tmr_start;
    logic [11:0]   tmr_load;
    logic          resume_reset_n;
    logic          memory_rail_good_oe_n;
    logic          core_rails_good_od_oe_n;
    logic          core_rails_good;
    logic          interrupt_line;
    logic          processor_hot_oe_n;
    logic          shutdown_warning_n;
    logic          button_to_host_n;
    pmpc_rail_en_s en;
  } pmpc_ctl_s;

endpackage

// file: src/pmpc_ctl.sv
// platform control signal sequencer of the power management device
`timescale 1ns/100ps
`default_nettype none
`include "pmpc_map.svh"

module pmpc_ctl
  import pmpc_pkg::*;
(
  // clock, reset, enable
  input  wire logic          clk,
  input  wire logic          sys_rst,
  input  wire logic          clk_en,
  // host system-on-chip inputs, asynchronous
  input  wire pmpc_host_in_s host_in,
  // internal status from regulators and monitors
  input  wire logic          a_rails_good,
  input  wire logic          memory_rail_above90,
  input  wire logic          core_softstart_done,
  input  wire logic          irq_pending,
  input  wire logic [2:0]    temp_alert,
  input  wire logic          fault_shutdown_req,
  input  wire logic          button_input_n,
  // rail enables
  output pmpc_rail_en_s      rail_en,
  // host outputs
  output logic               resume_reset_n,
  output logic               memory_rail_good_oe_n,
  output logic               core_rails_good_od_oe_n,
  output logic               core_rails_good,
  output logic               interrupt_line,
  output logic               processor_hot_oe_n,
  output logic               shutdown_warning_n,
  output logic               button_to_host_n
);

  // the timer ends one cycle after reaching zero, hence the minus one
  localparam logic [11:0] STEP_LOAD = 12'(`PMPC_STEP_CYC - 1);
  localparam logic [11:0] WARN_LOAD = 12'(`PMPC_WARN_CYC - 1);

  pmpc_host_in_s hs;
  logic          tmr_done;
  logic          trip_fall;
  logic          btn_fall;
  logic          rsm_hi;
  logic          deep_now;
  logic          ack_ok;
  logic          fault_ok;
  logic          hot_any;
  logic          sleep3_low;
  logic          wake_req;
  logic          shallow_low;

  pmpc_ctl_s r;
  pmpc_ctl_s next_r;

  // host inputs only reach the sequencer through two flops
  pmpc_sync #(
    .W    (6),
    .IDLE (`PMPC_HOST_IDLE)
  ) u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .clk_en  (clk_en),
    .din     (host_in),
    .dout    (hs)
  );

  // one timer paces both the power-down steps and the warning window
  pmpc_timer u_tmr (
    .clk     (clk),
    .sys_rst (sys_rst),
    .clk_en  (clk_en),
    .start   (r.tmr_start),
    .load    (r.tmr_load),
    .done    (tmr_done)
  );

  assign rsm_hi = r.resume_reset_n;

  // trips while the host is still in reset are sequencing noise
  assign trip_fall = r.trip_prev & ~hs.thermal_trip_n & hs.platform_reset_n;

  assign btn_fall = r.btn_prev & ~button_input_n;

  // sleep3 is only honoured once resume reset is released
  assign sleep3_low = ~hs.sleep_state3_n & rsm_hi;
  assign wake_req   = hs.sleep_state3_n & rsm_hi;

  // deep sleep counts only while sleep3 is asserted
  assign deep_now = ~hs.deep_sleep_n & ~hs.sleep_state3_n;

  // acknowledge honoured only in standby with the deep flag up
  assign ack_ok = hs.suspend_powerdown_ack & r.deep & rsm_hi;

  // nothing left to warn about when already off or warning
  assign fault_ok = fault_shutdown_req & (r.st != PMPC_OFF) & (r.st != PMPC_WARN);

  // outside a fault warning, regulators stay in power-save only as long as the host idles
  assign shallow_low = ~hs.shallow_sleep_n;

  // device, battery and system alerts share one pin
  assign hot_any = |temp_alert;

  always_comb begin
    next_r           = r;
    next_r.tmr_start = 1'b0;
    // trip edge history is kept only while the host is out of reset
    next_r.trip_prev = hs.platform_reset_n ? hs.thermal_trip_n : 1'b1;
    next_r.btn_prev  = button_input_n;

    if (trip_fall) begin
      // no warning window here: the trip demands an immediate stop
      next_r.st                 = PMPC_OFF;
      next_r.en                 = '0;
      next_r.step               = 2'h0;
      next_r.deep               = 1'b0;
      next_r.resume_reset_n     = 1'b0;
      next_r.core_rails_good    = 1'b0;
      next_r.shutdown_warning_n = 1'b1;
    end else if (fault_ok) begin
      next_r.st                 = PMPC_WARN;
      next_r.shutdown_warning_n = 1'b0;
      next_r.tmr_start          = 1'b1;
      next_r.tmr_load           = WARN_LOAD;
    end else begin
      // state machine runs only when neither trip nor fault takes over
      case (r.st)
        PMPC_OFF: begin
          // only a button press leaves off; host inputs are ignored here
          next_r.en             = '0;
          next_r.resume_reset_n = 1'b0;
          if (btn_fall) begin
            next_r.st         = PMPC_A_UP;
            next_r.en.a_rails = 1'b1;
          end
        end

        PMPC_A_UP: begin
          if (a_rails_good) begin
            next_r.st             = PMPC_STBY;
            next_r.resume_reset_n = 1'b1;
            // no deep flag until the host has asked for sleep
            next_r.deep           = 1'b0;
          end
        end

        PMPC_STBY: begin
          // flag rebuilt every cycle from the synchronised levels
          next_r.deep = deep_now;
          if (ack_ok) begin
            next_r.st                 = PMPC_A_DOWN;
            next_r.shutdown_warning_n = 1'b0;
            next_r.en.a_rails         = 1'b0;
            next_r.tmr_start          = 1'b1;
            next_r.tmr_load           = STEP_LOAD;
          end else if (wake_req) begin
            next_r.st             = PMPC_MAIN_UP;
            next_r.en.memory_rail = 1'b1;
            next_r.en.core_rails  = 1'b1;
          end
        end

        PMPC_MAIN_UP: begin
          // a sleep request wins over a late soft-start
          if (sleep3_low) begin
            next_r.st                 = PMPC_PWRDN;
            next_r.step               = 2'h0;
            next_r.shutdown_warning_n = 1'b0;
            next_r.tmr_start          = 1'b1;
            next_r.tmr_load           = STEP_LOAD;
          end else if (core_softstart_done) begin
            next_r.st              = PMPC_ON;
            next_r.core_rails_good = 1'b1;
          end
        end

        PMPC_ON: begin
          // core good stays up through shallow idle
          next_r.en.power_save = shallow_low;
          if (sleep3_low) begin
            next_r.st                 = PMPC_PWRDN;
            next_r.step               = 2'h0;
            next_r.en.power_save      = 1'b0;
            next_r.shutdown_warning_n = 1'b0;
            next_r.tmr_start          = 1'b1;
            next_r.tmr_load           = STEP_LOAD;
          end
        end

        PMPC_PWRDN: begin
          // ordered power-down: core group first, then memory
          if (r.step == 2'h0) begin
            next_r.en.core_rails   = 1'b0;
            next_r.core_rails_good = 1'b0;
            if (tmr_done) begin
              next_r.step      = 2'h1;
              next_r.tmr_start = 1'b1;
              next_r.tmr_load  = STEP_LOAD;
            end
          end else begin
            next_r.en.memory_rail = 1'b0;
            if (tmr_done) begin
              next_r.st                 = PMPC_STBY;
              next_r.step               = 2'h0;
              next_r.deep               = ~hs.deep_sleep_n;
              next_r.shutdown_warning_n = 1'b1;
            end
          end
        end

        PMPC_A_DOWN: begin
          // resume reset drops only once the always-on rails are gone
          if (tmr_done) begin
            next_r.st                 = PMPC_OFF;
            next_r.resume_reset_n     = 1'b0;
            next_r.deep               = 1'b0;
            next_r.shutdown_warning_n = 1'b1;
          end
        end

        PMPC_WARN: begin
          // rails keep running until the warning window has elapsed
          if (tmr_done) begin
            next_r.st                 = PMPC_OFF;
            next_r.en                 = '0;
            next_r.step               = 2'h0;
            next_r.deep               = 1'b0;
            next_r.resume_reset_n     = 1'b0;
            next_r.core_rails_good    = 1'b0;
            next_r.shutdown_warning_n = 1'b1;
          end
        end

        default: begin
          next_r.st = PMPC_OFF;
        end
      endcase
    end

    // memory good follows the rail enable and its threshold
    next_r.memory_rail_good_oe_n = next_r.en.memory_rail & memory_rail_above90;
    next_r.core_rails_good_od_oe_n = next_r.core_rails_good;

    // one-cycle answer, far inside the latency budget
    next_r.interrupt_line = irq_pending & rsm_hi;

    next_r.processor_hot_oe_n = ~(hot_any & rsm_hi & hs.platform_reset_n);

    // button forwarded only once resume reset is released
    next_r.button_to_host_n = rsm_hi ? button_input_n : 1'b1;
  end

  // reset leaves every pin at its idle level
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r                         <= '0;
      r.st                      <= PMPC_OFF;
      r.trip_prev               <= 1'b1;
      r.btn_prev                <= 1'b1;
      r.processor_hot_oe_n      <= 1'b1;
      r.shutdown_warning_n      <= 1'b1;
      r.button_to_host_n        <= 1'b1;
    end else if (clk_en) begin
      r <= next_r;
    end
  end

  assign rail_en                 = r.en;
  assign resume_reset_n          = r.resume_reset_n;
  assign memory_rail_good_oe_n   = r.memory_rail_good_oe_n;
  assign core_rails_good_od_oe_n = r.core_rails_good_od_oe_n;
  assign core_rails_good         = r.core_rails_good;
  assign interrupt_line          = r.interrupt_line;
  assign processor_hot_oe_n      = r.processor_hot_oe_n;
  assign shutdown_warning_n      = r.shutdown_warning_n;
  assign button_to_host_n        = r.button_to_host_n;

endmodule // pmpc_ctl

`default_nettype wire

// file: src/pmpc_sync.sv
// two-flop synchroniser for the host inputs
`timescale 1ns/100ps
`default_nettype none

module pmpc_sync
  import pmpc_pkg::*;
#(
  parameter int           W       = 6,
  parameter logic [W-1:0] IDLE    = '0
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic         clk_en,
  // data
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_s;

  sync_s r;
  sync_s next_r;

  // first stage feeds only the second stage
  always_comb begin
    next_r.s1 = din;
    next_r.s2 = r.s1;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r <= '{s1: IDLE, s2: IDLE};
    end else if (clk_en) begin
      r <= next_r;
    end
  end

  assign dout = r.s2;

endmodule // pmpc_sync

`default_nettype wire

// file: src/pmpc_timer.sv
// one-shot down counter for sequencing delays
`timescale 1ns/100ps
`default_nettype none

module pmpc_timer
  import pmpc_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  // control
  input  wire logic        start,
  input  wire logic [11:0] load,
  output logic             done
);

  pmpc_tmr_s r;
  pmpc_tmr_s next_r;

  always_comb begin
    next_r      = r;
    next_r.done = 1'b0;
    if (start) begin
      // a restart while busy simply reloads
      next_r.cnt  = load;
      next_r.busy = 1'b1;
    end else if (r.busy) begin
      if (r.cnt == 12'h000) begin
        next_r.busy = 1'b0;
        next_r.done = 1'b1;
      end else begin
        next_r.cnt = r.cnt - 12'h001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r <= '0;
    end else if (clk_en) begin
      r <= next_r;
    end
  end

  assign done = r.done;

endmodule // pmpc_timer

`default_nettype wire
